// ==== hw/ersr_recovery.sv ====
// What this block does
// (RULE1) Error read first gets 200 us fly check.
// (RULE2) Fly-correctable sector goes to host, no reread.
// (RULE3) Otherwise reread before any triple-burst correction.
// (RULE4) Each reread: all-zero syndromes means clean transfer.
// (RULE5) Nonzero syndromes stored, another reread started.
// (RULE6) Equal syndromes on consecutive rereads mean stable.
// (RULE7) Early correction plus stable runs triple correction.
// (RULE8) Early correction and remap enabled separately.
// (RULE9) Remap enabled allows eight times retry count.
// (RULE10) Remap enable is set after reset.
// (RULE11) Two spare sectors reserved per cylinder.
// (RULE12) Factory defect slipped inline, order kept sequential.
// (RULE13) Beyond two per cylinder, nearest spare elsewhere.
// (RULE14) Grown defects never slipped, remapped to spares.
// (RULE15) Triple-corrected sector counts as grown defect.
// (RULE16) Successful correction written into replacement sector.
// (RULE17) Failed correction written with uncorrectable marker.
// (RULE18) Marker reports errors until host rewrites sector.
// (RULE19) Syndrome set is 24 plus four cross-check.
// (RULE20) Fly-correctable only with two bad bytes per interleave.
// (RULE21) Uncorrectable when an interleave has over three.
// (RULE22) Retries exhausted: triple correction on last syndromes.
`timescale 1ns/1ps
module ersr_recovery
  import ersr_pkg::*;
#(
  parameter int CHECK_CYC = ERSR_FLY_CHECK_CYC,
  parameter int NCYL = 16,
  parameter int CYL_W = 4,
  parameter int LBA_W = 16,
  parameter int MARKS = 4
)(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Read channel results.
  input wire logic rd_done_i,
  input wire logic [ERSR_SYN_W-1:0] rd_syn_i,
  input wire logic [ERSR_IL_N*ERSR_ILCNT_W-1:0] rd_ilcnt_i,
  input wire logic [LBA_W-1:0] rd_lba_i,
  input wire logic [CYL_W-1:0] rd_cyl_i,
  output logic reread_o,
  output logic busy_o,
  // Host transfer path.
  input wire logic host_wr_i,
  input wire logic [LBA_W-1:0] host_wr_lba_i,
  output logic xfer_valid_o,
  output logic xfer_err_o,
  output logic xfer_corrected_o,
  // Replacement sector writes.
  output logic spare_wr_o,
  output logic [CYL_W-1:0] spare_cyl_o,
  output logic spare_idx_o,
  output logic spare_bad_o
);

  // ==========================================================================
  // State.
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_WAIT, ST_TRIPLE, ST_SPARE
  } ersr_st_t;

  typedef struct packed {
    ersr_st_t st;
    logic [13:0] cnt;
    logic [10:0] tries;
    logic [ERSR_SYN_W-1:0] syn;
    logic syn_prev;
    logic [ERSR_IL_N*ERSR_ILCNT_W-1:0] ilcnt;
    logic [LBA_W-1:0] lba;
    logic [CYL_W-1:0] cyl;
    logic stable;
    logic fix_ok;
    logic early_correction_enable;
    logic auto_read_remap_enable;
    logic busy;
    logic [ERSR_RETRY_W-1:0] retry;
    logic [NCYL-1:0][1:0] used;
    logic [NCYL-1:0][1:0] slip;
    logic [MARKS-1:0] mark_v;
    logic [MARKS-1:0][LBA_W-1:0] mark_lba;
    logic [$clog2(MARKS)-1:0] mark_ptr;
    logic [31:0] spare_reg;
    logic [31:0] rdata;
    logic reread;
    logic xv;
    logic xe;
    logic xc;
    logic sw;
    logic [CYL_W-1:0] sc;
    logic si;
    logic sb;
  } ersr_state_t;

  ersr_state_t q, d;

  // ==========================================================================
  // Helpers.

  // True when no interleave holds more than lim bad bytes.
  function automatic logic il_fits(
    input logic [ERSR_IL_N*ERSR_ILCNT_W-1:0] c,
    input logic [2:0] lim
  );
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < ERSR_IL_N; i++)
    begin
      if (c[i*ERSR_ILCNT_W +: ERSR_ILCNT_W] > lim)
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Nearest cylinder with a free spare, lower side first on a tie.
  // Searching outward keeps actuator travel to the replacement short.
  function automatic logic [CYL_W:0] near_free(
    input logic [NCYL-1:0][1:0] used,
    input logic [CYL_W-1:0] c
  );
    logic [CYL_W:0] r;
    int lo;
    int hi;
    r = '0;
    for (int k = NCYL - 1; k >= 0; k--)
    begin
      lo = int'(c) - k;
      hi = int'(c) + k;
      if (hi < NCYL && used[hi] != ERSR_SPARES_PER_CYL)
      begin
        r = {1'b1, hi[CYL_W-1:0]};
      end
      if (lo >= 0 && used[lo] != ERSR_SPARES_PER_CYL)
      begin
        r = {1'b1, lo[CYL_W-1:0]};
      end
    end
    return r;
  endfunction

  // Read results and limits that the idle, check and wait states look at.
  logic syn_zero;
  logic rd_marked;
  logic fly_ok;
  logic [10:0] limit;
  assign syn_zero = ~|rd_syn_i;
  assign fly_ok = il_fits(q.ilcnt, ERSR_FLY_MAX); // [RULE20]
  assign limit = q.auto_read_remap_enable
               ? (11'(q.retry) << ERSR_RETRY_MULT_SH)
               : 11'(q.retry); // [RULE9]

  always_comb
  begin
    rd_marked = 1'b0;
    for (int i = 0; i < MARKS; i++)
    begin
      if (q.mark_v[i] && q.mark_lba[i] == rd_lba_i)
      begin
        rd_marked = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Next-state logic: recovery sequence, sparing and register port.
  always_comb
  begin
    logic [CYL_W:0] nf;
    logic [CYL_W-1:0] dc;
    d = q;
    nf = '0;
    dc = '0;
    d.reread = 1'b0;
    d.xv = 1'b0;
    d.xe = 1'b0;
    d.xc = 1'b0;
    d.sw = 1'b0;
    d.rdata = '0;

    // A host write replaces the sector, so its marker goes away.
    if (host_wr_i)
    begin
      for (int i = 0; i < MARKS; i++)
      begin
        if (q.mark_lba[i] == host_wr_lba_i)
        begin
          d.mark_v[i] = 1'b0; // [RULE18]
        end
      end
    end

    case (q.st)
      ST_IDLE:
      begin
        if (rd_done_i)
        begin
          d.lba = rd_lba_i;
          d.cyl = rd_cyl_i;
          d.ilcnt = rd_ilcnt_i;
          d.syn_prev = 1'b0;
          d.stable = 1'b0;
          d.tries = '0;
          if (rd_marked)
          begin
            d.xv = 1'b1; // [RULE18]
            d.xe = 1'b1;
          end
          else if (syn_zero)
          begin
            d.xv = 1'b1;
          end
          else
          begin
            d.st = ST_CHECK; // [RULE1]
            d.cnt = '0;
          end
        end
      end
      ST_CHECK:
      begin
        d.cnt = q.cnt + 14'h0001;
        if (q.cnt == 14'(CHECK_CYC - 1))
        begin
          if (fly_ok)
          begin
            d.xv = 1'b1; // [RULE2]
            d.xc = 1'b1;
            d.st = ST_IDLE;
          end
          else
          begin
            d.reread = 1'b1; // [RULE3]
            d.st = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        if (rd_done_i)
        begin
          d.ilcnt = rd_ilcnt_i;
          d.tries = q.tries + 11'h001;
          if (syn_zero)
          begin
            d.xv = 1'b1; // [RULE4]
            d.st = ST_IDLE;
          end
          else
          begin
            // Compare against the previous reread only, never the first read.
            d.stable = q.syn_prev && (rd_syn_i == q.syn); // [RULE6]
            d.syn = rd_syn_i; // [RULE5] [RULE19]
            d.syn_prev = 1'b1;
            if (d.stable && q.early_correction_enable && d.tries < limit)
            begin
              d.st = ST_TRIPLE; // [RULE7]
            end
            else if (d.tries >= limit)
            begin
              d.st = ST_TRIPLE; // [RULE22]
            end
            else
            begin
              d.reread = 1'b1; // [RULE5]
            end
          end
        end
      end
      ST_TRIPLE:
      begin
        d.fix_ok = il_fits(q.ilcnt, ERSR_TRIPLE_MAX); // [RULE21]
        d.st = ST_SPARE;
      end
      ST_SPARE:
      begin
        // Needing triple correction marks a grown defect: remap, no slip.
        d.xv = 1'b1; // [RULE15]
        d.xe = ~q.fix_ok;
        d.xc = q.fix_ok;
        d.st = ST_IDLE;
        if (q.auto_read_remap_enable)
        begin
          nf = near_free(q.used, q.cyl); // [RULE14] [RULE8]
          dc = nf[CYL_W-1:0];
          d.spare_reg = '0;
          d.spare_reg[CYL_W-1:0] = dc;
          d.spare_reg[ERSR_SPARE_IDX_BIT] = q.used[dc][0];
          d.spare_reg[ERSR_SPARE_OK_BIT] = nf[CYL_W];
          d.spare_reg[ERSR_SPARE_FULL_BIT] = ~nf[CYL_W];
          if (nf[CYL_W])
          begin
            d.sw = 1'b1; // [RULE16]
            d.sc = dc;
            d.si = q.used[dc][0];
            d.sb = ~q.fix_ok; // [RULE17]
            d.used[dc] = q.used[dc] + 2'h1; // [RULE11]
            if (!q.fix_ok)
            begin
              d.mark_v[q.mark_ptr] = 1'b1; // [RULE17]
              d.mark_lba[q.mark_ptr] = q.lba;
              d.mark_ptr = q.mark_ptr + 1'b1;
            end
          end
        end
      end
      default:
      begin
        d.st = ST_IDLE;
      end
    endcase

    // Busy is registered beside the state so the output has no decode.
    d.busy = (d.st != ST_IDLE);

    // Register writes; the factory defect path sees any spare just taken.
    if (reg_we_i)
    begin
      if (reg_addr_i == ERSR_CFG_OFS)
      begin
        d.early_correction_enable = reg_wdata_i[ERSR_CFG_EARLY_BIT]; // [RULE8]
        d.auto_read_remap_enable = reg_wdata_i[ERSR_CFG_REMAP_BIT];
        d.retry = reg_wdata_i[ERSR_CFG_RETRY_LSB +: ERSR_RETRY_W];
      end
      else if (reg_addr_i == ERSR_DEFECT_OFS)
      begin
        dc = reg_wdata_i[CYL_W-1:0];
        d.spare_reg = '0;
        if (reg_wdata_i[ERSR_DEFECT_FACT_BIT] &&
            d.slip[dc] != ERSR_SPARES_PER_CYL &&
            d.used[dc] != ERSR_SPARES_PER_CYL)
        begin
          // Slipping uses this cylinder's own spare; LBAs stay in order.
          d.slip[dc] = d.slip[dc] + 2'h1; // [RULE12]
          d.used[dc] = d.used[dc] + 2'h1;
          d.spare_reg[CYL_W-1:0] = dc;
          d.spare_reg[ERSR_SPARE_OK_BIT] = 1'b1;
        end
        else
        begin
          nf = near_free(d.used, dc); // [RULE13] [RULE14]
          d.spare_reg[CYL_W-1:0] = nf[CYL_W-1:0];
          d.spare_reg[ERSR_SPARE_IDX_BIT] = d.used[nf[CYL_W-1:0]][0];
          d.spare_reg[ERSR_SPARE_OK_BIT] = nf[CYL_W];
          d.spare_reg[ERSR_SPARE_FULL_BIT] = ~nf[CYL_W];
          if (nf[CYL_W])
          begin
            d.used[nf[CYL_W-1:0]] = d.used[nf[CYL_W-1:0]] + 2'h1;
          end
        end
      end
    end

    // Read data stands in the cycle after the strobe only.
    if (reg_re_i)
    begin
      if (reg_addr_i == ERSR_CFG_OFS)
      begin
        d.rdata[ERSR_CFG_EARLY_BIT] = q.early_correction_enable;
        d.rdata[ERSR_CFG_REMAP_BIT] = q.auto_read_remap_enable;
        d.rdata[ERSR_CFG_RETRY_LSB +: ERSR_RETRY_W] = q.retry;
      end
      else if (reg_addr_i == ERSR_STAT_OFS)
      begin
        d.rdata[2:0] = q.st;
        d.rdata[ERSR_STAT_STABLE_BIT] = q.stable;
        d.rdata[ERSR_STAT_BAD_BIT] = ~q.fix_ok;
        d.rdata[ERSR_STAT_CNT_LSB +: 11] = q.tries;
      end
      else if (reg_addr_i == ERSR_SPARE_OFS)
      begin
        d.rdata = q.spare_reg;
      end
    end
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.fix_ok <= 1'b1;
      q.early_correction_enable <= ERSR_EARLY_RST;
      q.auto_read_remap_enable <= ERSR_REMAP_RST; // [RULE10]
      q.retry <= ERSR_RETRY_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata_o = q.rdata;
  assign reread_o = q.reread;
  assign busy_o = q.busy;
  assign xfer_valid_o = q.xv;
  assign xfer_err_o = q.xe;
  assign xfer_corrected_o = q.xc;
  assign spare_wr_o = q.sw;
  assign spare_cyl_o = q.sc;
  assign spare_idx_o = q.si;
  assign spare_bad_o = q.sb;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  logic chk_end;
  logic wait_err;
  assign chk_end = (q.st == ST_CHECK) && (q.cnt == 14'(CHECK_CYC - 1));
  assign wait_err = (q.st == ST_WAIT) && rd_done_i && !syn_zero;

  a_check_enter: assert property ( // [RULE1]
    (q.st == ST_IDLE && rd_done_i && !syn_zero && !rd_marked)
    |=> (q.st == ST_CHECK && q.cnt == 14'h0000))
    else $error("error read did not start the fly check");
  a_check_hold: assert property ( // [RULE1]
    (q.st == ST_CHECK && !chk_end) |=> (q.st == ST_CHECK && !q.xv))
    else $error("fly check left early");
  a_fly_pass: assert property ( // [RULE2]
    (chk_end && fly_ok) |=> (q.xv && q.xc && !q.xe && !q.reread))
    else $error("fly-correctable sector not delivered");
  a_reread_first: assert property ( // [RULE3]
    (chk_end && !fly_ok) |=> (q.reread && q.st == ST_WAIT && !q.xv))
    else $error("no reread after failed fly check");
  a_clean_reread: assert property ( // [RULE4]
    (q.st == ST_WAIT && rd_done_i && syn_zero)
    |=> (q.xv && !q.xe && q.st == ST_IDLE))
    else $error("clean reread not delivered");
  a_retry_again: assert property ( // [RULE5]
    (wait_err && (q.tries + 11'h001) < limit &&
     !q.early_correction_enable)
    |=> (q.reread && q.syn == $past(rd_syn_i)))
    else $error("nonzero syndromes did not start a reread");
  a_early_fix: assert property ( // [RULE7]
    (wait_err && q.early_correction_enable && q.syn_prev &&
     rd_syn_i == q.syn &&
     (q.tries + 11'h001) < limit)
    |=> (q.stable && q.st == ST_TRIPLE) ##2 q.xv)
    else $error("stable syndrome not corrected early");
  a_limit_fix: assert property ( // [RULE22]
    (wait_err && (q.tries + 11'h001) >= limit)
    |=> q.st == ST_TRIPLE ##1 q.st == ST_SPARE ##1 q.xv)
    else $error("exhausted retries did not run correction");
  a_remap_default: assert property ( // [RULE10]
    $fell(srst_i) |-> q.auto_read_remap_enable)
    else $error("remap not enabled after reset");
  a_spare_mark: assert property ( // [RULE17]
    q.sw |-> (q.sb == q.xe && q.xv && q.used[q.sc] != 2'h0))
    else $error("replacement marker disagrees with outcome");
  a_mark_report: assert property ( // [RULE18]
    (q.st == ST_IDLE && rd_done_i && rd_marked) |=> (q.xv && q.xe))
    else $error("marked sector read without an error");

  c_fly_fix: cover property (chk_end && fly_ok);
  c_early_stable: cover property (q.st == ST_TRIPLE && q.stable);
  c_bad_remap: cover property (q.sw && q.sb);
  c_marked_read: cover property (q.st == ST_IDLE && rd_done_i && rd_marked);

endmodule

// ==== pkg/ersr_pkg.sv ====
package ersr_pkg;

  // ==========================================================================
  // Register map, byte addresses on the plain register port.
  localparam logic [7:0] ERSR_CFG_OFS = 8'h00;
  localparam logic [7:0] ERSR_STAT_OFS = 8'h04;
  localparam logic [7:0] ERSR_DEFECT_OFS = 8'h08;
  localparam logic [7:0] ERSR_SPARE_OFS = 8'h0C;

  // ==========================================================================
  // Configuration register fields and reset values.
  localparam int ERSR_CFG_EARLY_BIT = 0;
  localparam int ERSR_CFG_REMAP_BIT = 1;
  localparam int ERSR_CFG_RETRY_LSB = 8;
  localparam int ERSR_RETRY_W = 8;
  localparam logic ERSR_EARLY_RST = 1'b0;
  localparam logic ERSR_REMAP_RST = 1'b1;
  localparam logic [7:0] ERSR_RETRY_RST = 8'h04;

  // Defect register: cylinder in the low bits, factory flag on top.
  localparam int ERSR_DEFECT_FACT_BIT = 31;
  // Spare register fields.
  localparam int ERSR_SPARE_IDX_BIT = 8;
  localparam int ERSR_SPARE_OK_BIT = 16;
  localparam int ERSR_SPARE_FULL_BIT = 17;
  // Status register fields.
  localparam int ERSR_STAT_STABLE_BIT = 8;
  localparam int ERSR_STAT_BAD_BIT = 9;
  localparam int ERSR_STAT_CNT_LSB = 16;

  // ==========================================================================
  // Sector code geometry.
  localparam int ERSR_ECC_SYN_N = 24;
  localparam int ERSR_XC_SYN_N = 4;
  localparam int ERSR_SYN_W = (ERSR_ECC_SYN_N + ERSR_XC_SYN_N) * 8;
  localparam int ERSR_IL_N = 4;
  localparam int ERSR_ILCNT_W = 3;
  localparam logic [2:0] ERSR_FLY_MAX = 3'h2;
  localparam logic [2:0] ERSR_TRIPLE_MAX = 3'h3;
  localparam int ERSR_RETRY_MULT_SH = 3;
  localparam logic [1:0] ERSR_SPARES_PER_CYL = 2'h2;

  // ==========================================================================
  // Timing.
  localparam int ERSR_CLK_MHZ = 50;
  localparam int ERSR_FLY_CHECK_US = 200;
  localparam int ERSR_FLY_CHECK_CYC = ERSR_FLY_CHECK_US * ERSR_CLK_MHZ;

endpackage

// ==== tb/ersr_chan_model.sv ====
`timescale 1ns/1ps
// ============================================================
// Read channel stand-in: answers every read or reread request
// with one syndrome set, after a short or a long settling time.
module ersr_chan_model
  import ersr_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Requests.
  input wire logic start_i,
  input wire logic reread_i,
  input wire logic slow_i,
  // Read script.
  input wire logic [ERSR_SYN_W-1:0] base_syn_i,
  input wire logic [3:0] n_vary_i,
  input wire logic [3:0] clean_after_i,
  input wire logic [11:0] il_i,
  input wire logic [15:0] lba_i,
  input wire logic [3:0] cyl_i,
  // Result towards the block.
  output logic rd_done_o,
  output logic [ERSR_SYN_W-1:0] rd_syn_o,
  output logic [11:0] rd_ilcnt_o,
  output logic [15:0] rd_lba_o,
  output logic [3:0] rd_cyl_o
);
  logic [3:0] k_q;
  logic [4:0] tmr_q;
  logic [ERSR_SYN_W-1:0] syn;

  // Early reads differ, later ones repeat, all zero once clean.
  always_comb
  begin
    syn = base_syn_i ^ ((k_q < n_vary_i) ? ERSR_SYN_W'(k_q + 4'h1) : '0);
    if (clean_after_i != 4'h0 && k_q >= clean_after_i)
    begin
      syn = '0;
    end
  end

  // Off the strobe the lines toggle, so stale data is never mistaken
  // for a fresh result by a sampler that looks at the wrong cycle.
  always @(posedge ref_clk_i)
  begin
    rd_done_o <= 1'b0;
    if (srst_i)
    begin
      tmr_q <= 5'h00;
      k_q <= 4'h0;
      rd_syn_o <= '0;
      rd_ilcnt_o <= 12'h000;
      rd_lba_o <= 16'h0000;
      rd_cyl_o <= 4'h0;
    end
    else if (start_i || reread_i)
    begin
      tmr_q <= slow_i ? 5'h0C : 5'h02;
      if (start_i)
      begin
        k_q <= 4'h0;
      end
    end
    else if (tmr_q == 5'h01)
    begin
      tmr_q <= 5'h00;
      rd_done_o <= 1'b1;
      rd_syn_o <= syn;
      rd_ilcnt_o <= il_i;
      rd_lba_o <= lba_i;
      rd_cyl_o <= cyl_i;
    end
    else
    begin
      tmr_q <= (tmr_q != 5'h00) ? tmr_q - 5'h01 : 5'h00;
      k_q <= rd_done_o ? k_q + 4'h1 : k_q;
      rd_syn_o <= ~rd_syn_o;
      rd_ilcnt_o <= ~rd_ilcnt_o;
      rd_lba_o <= ~rd_lba_o;
      rd_cyl_o <= ~rd_cyl_o;
    end
  end
endmodule

// ==== tb/ersr_tb_top.sv ====
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the recovery and sparing block.
module ecc_retry_and_sector_realloc_tb_top
  import ersr_pkg::*;
;
  localparam int CHK = 8;
  localparam logic [ERSR_SYN_W-1:0] BASE = ERSR_SYN_W'(32'h5A3C_0F10);
  logic clk, srst, reg_we, reg_re, rd_done, reread, busy, host_wr;
  logic xfer_valid, xfer_err, xfer_corr, spare_wr, spare_idx, spare_bad;
  logic start, slow;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [ERSR_SYN_W-1:0] rd_syn, base_syn;
  logic [11:0] rd_ilcnt, il;
  logic [15:0] rd_lba, lba, host_wr_lba;
  logic [3:0] rd_cyl, spare_cyl, n_vary, clean_after;
  logic r_err, r_corr, r_swr, r_sbad, r_sidx;
  logic [3:0] r_scyl;
  int r_nre, r_t, r_busy, errors, checks_done, cyc;

  // ============================================================
  // Instances.
  ersr_recovery #(.CHECK_CYC(CHK)) dut (.ref_clk_i(clk), .srst_i(srst),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(reg_rdata), .rd_done_i(rd_done),
    .rd_syn_i(rd_syn), .rd_ilcnt_i(rd_ilcnt), .rd_lba_i(rd_lba),
    .rd_cyl_i(rd_cyl), .reread_o(reread), .busy_o(busy),
    .host_wr_i(host_wr), .host_wr_lba_i(host_wr_lba),
    .xfer_valid_o(xfer_valid), .xfer_err_o(xfer_err),
    .xfer_corrected_o(xfer_corr), .spare_wr_o(spare_wr),
    .spare_cyl_o(spare_cyl), .spare_idx_o(spare_idx),
    .spare_bad_o(spare_bad));
  ersr_chan_model chan (.ref_clk_i(clk), .srst_i(srst), .start_i(start),
    .reread_i(reread), .slow_i(slow), .base_syn_i(base_syn),
    .n_vary_i(n_vary), .clean_after_i(clean_after), .il_i(il),
    .lba_i(lba), .cyl_i(4'h9), .rd_done_o(rd_done), .rd_syn_o(rd_syn),
    .rd_ilcnt_o(rd_ilcnt), .rd_lba_o(rd_lba), .rd_cyl_o(rd_cyl));

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  // A hang anywhere ends the run as a mismatch.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // ============================================================
  // Shared tasks.
  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input string what);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask

  // One sector read; r_t counts cycles from the last result strobe.
  task automatic run(input logic [ERSR_SYN_W-1:0] s, input logic [3:0] nv,
    input logic [3:0] ca, input logic [11:0] i, input logic [15:0] l,
    input logic sl);
    int t;
    t = -1;
    r_nre = 0;
    r_swr = 1'b0;
    r_t = -1;
    r_busy = 0;
    @(posedge clk);
    base_syn <= s;
    n_vary <= nv;
    clean_after <= ca;
    il <= i;
    lba <= l;
    slow <= sl;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int n = 0; n < 2000 && r_t < 0; n++)
    begin
      #1;
      t = rd_done ? 0 : ((t >= 0) ? t + 1 : t);
      if (reread === 1'b1)
        r_nre++;
      if (busy === 1'b1)
        r_busy++;
      if (spare_wr === 1'b1)
      begin
        r_swr = 1'b1;
        r_sbad = spare_bad;
        r_scyl = spare_cyl;
        r_sidx = spare_idx;
      end
      if (xfer_valid === 1'b1)
      begin
        r_t = t;
        r_err = xfer_err;
        r_corr = xfer_corr;
      end
      @(posedge clk);
    end
    chk("xfer seen", 32'h1, {31'h0, r_t >= 0});
  endtask

  task automatic chk_res(input int nre, input logic e, input logic c,
    input logic sw);
    chk("rereads", 32'(nre), 32'(r_nre));
    chk("xfer_err", {31'h0, e}, {31'h0, r_err});
    chk("xfer_corrected", {31'h0, c}, {31'h0, r_corr});
    chk("spare_wr", {31'h0, sw}, {31'h0, r_swr});
  endtask

  // ============================================================
  // Scenarios.
  task automatic t_regs();
    rd(ERSR_CFG_OFS, 32'h0000_0402, "cfg reset");
    rd(8'h10, 32'h0, "unmapped read");
    wr(8'h10, 32'hFFFF_FFFF);
    rd(ERSR_CFG_OFS, 32'h0000_0402, "cfg after stray");
  endtask

  task automatic t_clean_and_fly();
    run('0, 4'h0, 4'h0, 12'h000, 16'h0010, 1'b0);
    chk("clean delay", 32'h1, 32'(r_t));
    chk("clean busy", 32'h0, 32'(r_busy));
    chk_res(0, 1'b0, 1'b0, 1'b0);
    run(BASE, 4'h0, 4'h0, 12'h492, 16'h0011, 1'b0);
    chk("fly delay", 32'(CHK + 1), 32'(r_t));
    chk("fly busy", 32'(CHK), 32'(r_busy));
    chk_res(0, 1'b0, 1'b1, 1'b0);
  endtask

  task automatic t_reread_clean();
    run(BASE, 4'h0, 4'h1, 12'h493, 16'h0012, 1'b0);
    chk("reread delay", 32'h1, 32'(r_t));
    chk_res(1, 1'b0, 1'b0, 1'b0);
  endtask

  // Two differing rereads, then a repeat: stable on the third.
  task automatic t_stable_early();
    wr(ERSR_CFG_OFS, 32'h0000_0403);
    run(BASE, 4'h2, 4'h0, 12'h493, 16'h0013, 1'b1);
    chk_res(3, 1'b0, 1'b1, 1'b1);
    chk("spare bad", 32'h0, {31'h0, r_sbad});
    chk("spare place", 32'h0000_0009,
      {23'h0, r_sidx, 4'h0, r_scyl});
  endtask

  // Without remap the plain retry count bounds the rereads.
  task automatic t_limit_noremap();
    wr(ERSR_CFG_OFS, 32'h0000_0200);
    run(BASE, 4'hF, 4'h0, 12'h493, 16'h0014, 1'b0);
    chk_res(2, 1'b0, 1'b1, 1'b0);
  endtask

  // Stable syndromes but early correction off: all eight tries run.
  task automatic t_remap_fail();
    wr(ERSR_CFG_OFS, 32'h0000_0102);
    run(BASE, 4'h0, 4'h0, 12'h494, 16'h0077, 1'b0);
    chk_res(8, 1'b1, 1'b0, 1'b1);
    chk("spare bad", 32'h1, {31'h0, r_sbad});
    chk("spare place", 32'h0000_0109, {23'h0, r_sidx, 4'h0, r_scyl});
    rd(ERSR_STAT_OFS, 32'h0008_0300, "status");
    run('0, 4'h0, 4'h0, 12'h000, 16'h0077, 1'b0);
    chk("marked err", 32'h1, {31'h0, r_err});
    @(posedge clk);
    host_wr <= 1'b1;
    host_wr_lba <= 16'h0077;
    @(posedge clk);
    host_wr <= 1'b0;
    run('0, 4'h0, 4'h0, 12'h000, 16'h0077, 1'b0);
    chk("rewritten err", 32'h0, {31'h0, r_err});
  endtask

  task automatic t_defects();
    wr(ERSR_DEFECT_OFS, 32'h8000_0003);
    rd(ERSR_SPARE_OFS, 32'h0001_0003, "slip one");
    wr(ERSR_DEFECT_OFS, 32'h8000_0003);
    rd(ERSR_SPARE_OFS, 32'h0001_0003, "slip two");
    wr(ERSR_DEFECT_OFS, 32'h8000_0003);
    rd(ERSR_SPARE_OFS, 32'h0001_0002, "third defect");
    wr(ERSR_DEFECT_OFS, 32'h0000_0009);
    rd(ERSR_SPARE_OFS, 32'h0001_0008, "grown defect");
  endtask

  // ============================================================
  // Main sequence.
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    {reg_we, reg_re, host_wr, start, slow} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    host_wr_lba = 16'h0000;
    base_syn = '0;
    {n_vary, clean_after} = 8'h00;
    il = 12'h000;
    lba = 16'h0000;
    errors = 0;
    checks_done = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_clean_and_fly();
    t_reread_clean();
    t_stable_early();
    t_limit_noremap();
    t_remap_fail();
    t_defects();
    tally_and_finish();
  end
endmodule
